/* logic/flic_regs.svh */
// Register offsets, field positions, reset values and vectors of the interrupt controller
`ifndef FLIC_REGS_SVH
`define FLIC_REGS_SVH

// Register offsets
`define FLIC_ADDR_EN_MAIN 8'ha8
`define FLIC_ADDR_PL_MAIN 8'hb8
`define FLIC_ADDR_PH_MAIN 8'hb7
`define FLIC_ADDR_EN_SEC  8'hb1
`define FLIC_ADDR_PL_SEC  8'hb2
`define FLIC_ADDR_PH_SEC  8'hb3
`define FLIC_ADDR_STATUS  8'hc0

// Field positions, main enable and main priority registers
`define FLIC_BIT_GLOBAL 7
`define FLIC_BIT_PCA    6
`define FLIC_BIT_T2     5
`define FLIC_BIT_UART   4
`define FLIC_BIT_T1     3
`define FLIC_BIT_EXT1   2
`define FLIC_BIT_T0     1
`define FLIC_BIT_EXT0   0

// Field positions, second enable and second priority registers
`define FLIC_BIT_USB    6
`define FLIC_BIT_SPI    2
`define FLIC_BIT_KBD    0

// Writable masks and reset value
`define FLIC_MASK_EN_MAIN 8'hff
`define FLIC_MASK_PR_MAIN 8'h7f
`define FLIC_MASK_SEC     8'h45
`define FLIC_RST_VAL      8'h00

// Vector addresses
`define FLIC_VEC_EXT0 16'h0003
`define FLIC_VEC_T0   16'h000b
`define FLIC_VEC_EXT1 16'h0013
`define FLIC_VEC_T1   16'h001b
`define FLIC_VEC_UART 16'h0023
`define FLIC_VEC_T2   16'h002b
`define FLIC_VEC_PCA  16'h0033
`define FLIC_VEC_SPI  16'h0043
`define FLIC_VEC_KBD  16'h004b
`define FLIC_VEC_USB  16'h0053

`endif

/* logic/flic_pkg.sv */
// Types shared by the interrupt controller modules
package flic_pkg;
   typedef logic [1:0] flic_level_t;
   typedef logic [3:0] flic_idx_t;
   // Source index, also the polling order within a level
   typedef enum logic [3:0]
   {
      FLIC_SRC_EXT0 = 4'h0,
      FLIC_SRC_T0   = 4'h1,
      FLIC_SRC_EXT1 = 4'h2,
      FLIC_SRC_T1   = 4'h3,
      FLIC_SRC_UART = 4'h4,
      FLIC_SRC_T2   = 4'h5,
      FLIC_SRC_PCA  = 4'h6,
      FLIC_SRC_SPI  = 4'h7,
      FLIC_SRC_KBD  = 4'h8,
      FLIC_SRC_USB  = 4'h9
   } flic_src_e;
endpackage

/* logic/flic_link_if.sv */
// Carrier between the controller, its arbiter and its in-service tracker
`timescale 1ns/1ns
interface flic_link_if
   import flic_pkg::*;
   #(parameter int N_SRC = 10)
   ();
   logic [N_SRC-1:0]   req;
   logic [2*N_SRC-1:0] lvl;
   logic               win_valid;
   flic_idx_t          win_idx;
   flic_level_t        win_lvl;
   logic               ack;
   flic_level_t        ack_lvl;
   logic               ret;
   logic [3:0]         in_svc;
   logic               run_valid;
   flic_level_t        run_lvl;

   modport ctl (output req, lvl, ack, ack_lvl, ret,
                input win_valid, win_idx, win_lvl, in_svc, run_valid, run_lvl);
   modport arb (input req, lvl, output win_valid, win_idx, win_lvl);
   modport trk (input ack, ack_lvl, ret, output in_svc, run_valid, run_lvl);
endinterface

/* logic/flic_arbiter.sv */
// Level and polling-order arbiter over all gated requests
`timescale 1ns/1ns
module flic_arbiter
   import flic_pkg::*;
   #(parameter int N_SRC = 10)
   (
   flic_link_if.arb lnk
   );

   flic_level_t lvl_a [N_SRC];

   // Unpack the per-source level codes
   genvar g;
   generate
      for (g = 0; g < N_SRC; g++)
      begin : g_lvl
         assign lvl_a[g] = lnk.lvl[2*g +: 2];
      end
   endgenerate

   // Scan downward so the lowest index wins a tie at equal level
   always_comb
   begin
      lnk.win_valid = 1'b0;
      lnk.win_idx   = 4'h0;
      lnk.win_lvl   = 2'h0;
      for (int i = N_SRC - 1; i >= 0; i--)
      begin
         if (lnk.req[i] && (!lnk.win_valid || lvl_a[i] >= lnk.win_lvl)) // [R12] [R13] [R21]
         begin
            lnk.win_valid = 1'b1;
            lnk.win_idx   = 4'(i);
            lnk.win_lvl   = lvl_a[i];
         end
      end
   end
endmodule

/* logic/flic_tracker.sv */
// In-service level tracker, one bit per priority level
`timescale 1ns/1ns
module flic_tracker
   import flic_pkg::*;
   (
   input  wire logic clk,
   input  wire logic sys_rst,
   input  wire logic ce,
   flic_link_if.trk  lnk
   );

   logic [3:0] in_svc_r;
   logic [3:0] ret_mask;

   // Highest running level and the bit a return clears
   always_comb
   begin
      lnk.run_valid = |in_svc_r;
      lnk.run_lvl   = 2'h0;
      ret_mask      = 4'h0;
      for (int l = 0; l < 4; l++)
      begin
         if (in_svc_r[l])
         begin
            lnk.run_lvl = 2'(l);
         end
      end
      if (lnk.run_valid)
      begin
         ret_mask[lnk.run_lvl] = 1'b1;
      end
   end

   // Return clears first so a nested take in the same cycle survives
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         in_svc_r <= 4'h0;
      end
      else if (ce)
      begin
         in_svc_r <= (in_svc_r & ~(lnk.ret ? ret_mask : 4'h0))
                   | (lnk.ack ? (4'h1 << lnk.ack_lvl) : 4'h0);
      end
   end

   assign lnk.in_svc = in_svc_r;
endmodule

/* logic/flic_ctrl.sv */
// Four-level interrupt controller: enables, priorities, arbitration and core handshake
//
// Operation
// [R1] Ten distinct sources, each with its own vector address.
// [R2] A source with its enable bit at zero never reaches the core.
// [R3] Global enable at bit 7 of the main enable register blocks all when zero.
// [R4] Counter-array enable sits at bit 6 of the main enable register.
// [R5] Timer 0, 1, 2 enables sit at bits 1, 3, 5 of main enable.
// [R6] External 0 enable at bit 0, external 1 enable at bit 2.
// [R7] Serial port enable sits at bit 4 of the main enable register.
// [R8] Main enable resets to zero and accepts single-bit writes.
// [R9] Level code is high bit and low bit: 00 lowest up to 11 highest.
// [R10] A running handler is preempted only by a strictly higher level.
// [R11] A handler at level 3 is never preempted.
// [R12] Of simultaneous requests, the higher level is dispatched first.
// [R13] Equal-level requests are ordered by a fixed polling sequence.
// [R14] Counter array 0033h, SPI 0043h, keyboard 004bh vectors.
// [R15] Priority-low bits 0 to 6: ext0, t0, ext1, t1, serial, t2, counter array.
// [R16] Software never sets priority-low bit 7; its read value is meaningless.
// [R17] Priority-high mirrors priority-low layout in bits 0 to 6, resets to zero.
// [R18] Second enable: USB bit 6, SPI bit 2, keyboard bit 0.
// [R19] Priority-low resets to zero and accepts single-bit writes.
// [R20] Other vectors: 0003h, 000bh, 0013h, 001bh, 0023h, 002bh.
// [R21] Polling order within a level follows ascending vector address.
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ns
`include "flic_regs.svh"
module flic_ctrl
   import flic_pkg::*;
   #(parameter int N_SRC = 10)
   (
   input  wire logic             clk,
   input  wire logic             sys_rst,
   input  wire logic             ce,
   input  wire logic [7:0]       reg_addr,
   input  wire logic [7:0]       reg_wdata,
   input  wire logic             reg_we,
   input  wire logic             reg_re,
   output logic      [7:0]       reg_rdata,
   input  wire logic             bit_we,
   input  wire logic [2:0]       bit_sel,
   input  wire logic             bit_val,
   input  wire logic [N_SRC-1:0] src_req,
   output logic      [N_SRC-1:0] src_taken,
   output logic                  irq_req,
   output logic      [15:0]      irq_vector,
   output logic      [1:0]       irq_level,
   input  wire logic             irq_ack,
   input  wire logic             irq_ret
   );

   logic [7:0]       en_main_r;
   logic [7:0]       pl_main_r;
   logic [7:0]       ph_main_r;
   logic [7:0]       en_sec_r;
   logic [7:0]       pl_sec_r;
   logic [7:0]       ph_sec_r;
   logic [7:0]       rdata_r;
   logic [7:0]       rdata_nxt;
   logic [N_SRC-1:0] en_vec;
   logic [N_SRC-1:0] pl_vec;
   logic [N_SRC-1:0] ph_vec;
   logic [N_SRC-1:0] gate;
   logic             win_v_r;
   flic_idx_t        win_i_r;
   flic_level_t      win_l_r;
   logic [15:0]      vec_r;
   logic [N_SRC-1:0] taken_r;
   logic [N_SRC-1:0] win_onehot;
   logic [N_SRC-1:0] lvl_ok;
   logic             preempt_ok;
   logic             take;

   flic_link_if #(.N_SRC(N_SRC)) lnk ();

   flic_arbiter #(.N_SRC(N_SRC)) u_arb
   (
      .lnk (lnk.arb)
   );

   flic_tracker u_trk
   (
      .clk     (clk),
      .sys_rst (sys_rst),
      .ce      (ce),
      .lnk     (lnk.trk)
   );

   // Next register value for a byte write or a single-bit write
   function automatic logic [7:0] upd(input logic [7:0] old,
                                      input logic [7:0] msk,
                                      input logic [7:0] adr,
                                      input logic       bit_ok);
      logic [7:0] tmp;
      tmp = old;
      if (reg_we && reg_addr == adr)
      begin
         tmp = reg_wdata;
      end
      else if (bit_we && bit_ok && reg_addr == adr)
      begin
         tmp[bit_sel] = bit_val;
      end
      upd = tmp & msk;
   endfunction

   // Fixed vector per source; codes past the last source are illegal
   function automatic logic [15:0] vec_of(input flic_idx_t idx);
      unique case (flic_src_e'(idx))
         FLIC_SRC_EXT0: vec_of = `FLIC_VEC_EXT0; // [R20]
         FLIC_SRC_T0:   vec_of = `FLIC_VEC_T0;
         FLIC_SRC_EXT1: vec_of = `FLIC_VEC_EXT1;
         FLIC_SRC_T1:   vec_of = `FLIC_VEC_T1;
         FLIC_SRC_UART: vec_of = `FLIC_VEC_UART;
         FLIC_SRC_T2:   vec_of = `FLIC_VEC_T2;
         FLIC_SRC_PCA:  vec_of = `FLIC_VEC_PCA; // [R14]
         FLIC_SRC_SPI:  vec_of = `FLIC_VEC_SPI; // [R14]
         FLIC_SRC_KBD:  vec_of = `FLIC_VEC_KBD; // [R14]
         FLIC_SRC_USB:  vec_of = `FLIC_VEC_USB; // [R1]
         default:       vec_of = 16'h0000;
      endcase
   endfunction

   // Enable registers; reset leaves every source and the global gate off
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         en_main_r <= `FLIC_RST_VAL; // [R8]
         en_sec_r  <= `FLIC_RST_VAL;
      end
      else if (ce)
      begin
         en_main_r <= upd(en_main_r, `FLIC_MASK_EN_MAIN, `FLIC_ADDR_EN_MAIN, 1'b1); // [R8]
         en_sec_r  <= upd(en_sec_r, `FLIC_MASK_SEC, `FLIC_ADDR_EN_SEC, 1'b1); // [R18]
      end
   end

   // Priority registers; bit 7 is masked so a stray write cannot stick
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         pl_main_r <= `FLIC_RST_VAL; // [R19]
         ph_main_r <= `FLIC_RST_VAL; // [R17]
         pl_sec_r  <= `FLIC_RST_VAL;
         ph_sec_r  <= `FLIC_RST_VAL;
      end
      else if (ce)
      begin
         pl_main_r <= upd(pl_main_r, `FLIC_MASK_PR_MAIN, `FLIC_ADDR_PL_MAIN, 1'b1); // [R16]
         ph_main_r <= upd(ph_main_r, `FLIC_MASK_PR_MAIN, `FLIC_ADDR_PH_MAIN, 1'b0); // [R17]
         pl_sec_r  <= upd(pl_sec_r, `FLIC_MASK_SEC, `FLIC_ADDR_PL_SEC, 1'b1);
         ph_sec_r  <= upd(ph_sec_r, `FLIC_MASK_SEC, `FLIC_ADDR_PH_SEC, 1'b0);
      end
   end

   // Read multiplexer; unmapped addresses and reserved bits read zero
   always_comb
   begin
      unique case (reg_addr)
         `FLIC_ADDR_EN_MAIN: rdata_nxt = en_main_r;
         `FLIC_ADDR_PL_MAIN: rdata_nxt = pl_main_r;
         `FLIC_ADDR_PH_MAIN: rdata_nxt = ph_main_r;
         `FLIC_ADDR_EN_SEC:  rdata_nxt = en_sec_r;
         `FLIC_ADDR_PL_SEC:  rdata_nxt = pl_sec_r;
         `FLIC_ADDR_PH_SEC:  rdata_nxt = ph_sec_r;
         `FLIC_ADDR_STATUS:  rdata_nxt = {irq_req, 3'h0, lnk.in_svc};
         default:            rdata_nxt = 8'h00;
      endcase
   end

   // Read data stand only in the cycle after the strobe
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         rdata_r <= 8'h00;
      end
      else if (ce)
      begin
         rdata_r <= reg_re ? rdata_nxt : 8'h00;
      end
   end

   assign reg_rdata = rdata_r;

   // Map register fields onto source indices, in polling order
   assign en_vec = {en_sec_r[`FLIC_BIT_USB], en_sec_r[`FLIC_BIT_KBD],
                    en_sec_r[`FLIC_BIT_SPI], en_main_r[`FLIC_BIT_PCA], // [R4] [R18]
                    en_main_r[`FLIC_BIT_T2], en_main_r[`FLIC_BIT_UART], // [R5] [R7]
                    en_main_r[`FLIC_BIT_T1], en_main_r[`FLIC_BIT_EXT1], // [R5] [R6]
                    en_main_r[`FLIC_BIT_T0], en_main_r[`FLIC_BIT_EXT0]}; // [R5] [R6]
   assign pl_vec = {pl_sec_r[`FLIC_BIT_USB], pl_sec_r[`FLIC_BIT_KBD],
                    pl_sec_r[`FLIC_BIT_SPI], pl_main_r[6:0]}; // [R15]
   assign ph_vec = {ph_sec_r[`FLIC_BIT_USB], ph_sec_r[`FLIC_BIT_KBD],
                    ph_sec_r[`FLIC_BIT_SPI], ph_main_r[6:0]}; // [R17]

   // Gate each request by its own enable and by the global enable
   assign gate = src_req & en_vec & {N_SRC{en_main_r[`FLIC_BIT_GLOBAL]}}; // [R2] [R3]

   assign lnk.req = gate; // [R1]

   // Level code per source: high bit above low bit
   genvar g;
   generate
      for (g = 0; g < N_SRC; g++)
      begin : g_code
         assign lnk.lvl[2*g +: 2] = {ph_vec[g], pl_vec[g]}; // [R9]
         assign win_onehot[g]     = (win_i_r == 4'(g));
         assign lvl_ok[g]         = !lnk.req[g] || (lnk.lvl[2*g +: 2] <= lnk.win_lvl);
      end
   endgenerate

   // Winner pipeline; the arbiter ranks level first, then index
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         win_v_r <= 1'b0;
         win_i_r <= 4'h0;
         win_l_r <= 2'h0;
         vec_r   <= 16'h0000;
      end
      else if (ce)
      begin
         win_v_r <= lnk.win_valid; // [R12] [R13] [R21]
         win_i_r <= lnk.win_idx;
         win_l_r <= lnk.win_lvl;
         vec_r   <= vec_of(lnk.win_idx); // [R14] [R20]
      end
   end

   // Only a strictly higher level may nest; nothing exceeds level 3
   assign preempt_ok = !lnk.run_valid || (win_l_r > lnk.run_lvl); // [R10] [R11]

   // Re-gate with live enables so a just-cleared enable blocks at once
   assign irq_req = win_v_r && gate[win_i_r] && preempt_ok; // [R2] [R3]
   assign take    = irq_req && irq_ack && ce;

   assign lnk.ack     = take;
   assign lnk.ack_lvl = win_l_r;
   assign lnk.ret     = irq_ret && ce;

   // One-cycle notice to the source that its request was taken
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         taken_r <= '0;
      end
      else if (ce)
      begin
         taken_r <= take ? win_onehot : '0;
      end
   end

   assign src_taken  = taken_r;
   assign irq_vector = vec_r;
   assign irq_level  = win_l_r;

   AST_GATED: assert property (@(posedge clk) disable iff (sys_rst) // [R2]
      irq_req |-> en_vec[win_i_r] && src_req[win_i_r])
      else $error("request forwarded from a disabled source");

   AST_GLOBAL: assert property (@(posedge clk) disable iff (sys_rst) // [R3]
      !en_main_r[`FLIC_BIT_GLOBAL] |-> !irq_req && !take)
      else $error("request forwarded with global enable off");

   AST_EN_RESET: assert property (@(posedge clk) disable iff (sys_rst) // [R8]
      $past(sys_rst) |-> en_main_r == 8'h00 && pl_main_r == 8'h00
                         && ph_main_r == 8'h00)
      else $error("enable or priority not cleared by reset");

   AST_BIT7: assert property (@(posedge clk) disable iff (sys_rst) // [R16]
      pl_main_r[7] == 1'b0 && ph_main_r[7] == 1'b0)
      else $error("reserved priority bit became set");

   AST_NEST: assert property (@(posedge clk) disable iff (sys_rst) // [R10]
      take && lnk.run_valid |-> win_l_r > lnk.run_lvl)
      else $error("handler preempted by equal or lower level");

   AST_TOP: assert property (@(posedge clk) disable iff (sys_rst) // [R11]
      lnk.in_svc[3] |-> !irq_req)
      else $error("level 3 handler preempted");

   AST_HIGHER: assert property (@(posedge clk) disable iff (sys_rst || !ce) // [R12]
      lnk.win_valid |=> win_l_r == $past(lnk.win_lvl)
         && (($past(gate) & ~$past(win_onehot)) == '0 || win_v_r))
      else $error("winner level not carried to the core");

   AST_POLL: assert property (@(posedge clk) disable iff (sys_rst) // [R13]
      lnk.win_valid |-> lnk.req[lnk.win_idx]
         && lnk.lvl[2*lnk.win_idx +: 2] == lnk.win_lvl
         && (lnk.win_idx == 4'h0 || lnk.lvl[1:0] != lnk.win_lvl || !lnk.req[0]))
      else $error("polling order broken within a level");

   AST_VEC: assert property (@(posedge clk) disable iff (sys_rst) // [R14]
      irq_req && win_i_r == FLIC_SRC_PCA |-> irq_vector == 16'h0033)
      else $error("wrong counter-array vector");

   AST_TAKEN: assert property (@(posedge clk) disable iff (sys_rst) // [R1]
      take |=> src_taken == $past(win_onehot) ##1 (!ce || src_taken == '0 || $past(take)))
      else $error("taken pulse wrong or held");

   // Reset, freeze and register masks
   AST_RST_OUT: assert property (@(posedge clk) disable iff (sys_rst) // [R8]
      $past(sys_rst) |-> !irq_req && src_taken == '0 && irq_vector == 16'h0000
                         && irq_level == 2'h0)
      else $error("outputs not cleared by reset");

   AST_FREEZE: assert property (@(posedge clk) disable iff (sys_rst) // [R8]
      !ce |=> $stable(en_main_r) && $stable(pl_main_r) && $stable(ph_main_r)
              && $stable(lnk.in_svc))
      else $error("state moved while clock enable low");

   AST_SEC_MASK: assert property (@(posedge clk) disable iff (sys_rst) // [R18]
      ((en_sec_r | pl_sec_r | ph_sec_r) & ~`FLIC_MASK_SEC) == 8'h00)
      else $error("reserved second-register bit became set");

   // Arbitration, in-service tracking and taken pulse, checked apart from the arbiter
   AST_LEVEL_MAX: assert property (@(posedge clk) disable iff (sys_rst) // [R12]
      lnk.win_valid |-> &lvl_ok)
      else $error("a request above the winner level was passed over");

   AST_ACK_SET: assert property (@(posedge clk) disable iff (sys_rst) // [R10]
      take |=> lnk.in_svc[$past(win_l_r)])
      else $error("taken level not marked in service");

   AST_RET: assert property (@(posedge clk) disable iff (sys_rst) // [R10]
      lnk.ret && !lnk.ack |=> (lnk.in_svc & (4'h1 << $past(lnk.run_lvl))) == 4'h0)
      else $error("return left the running level in service");

   AST_ONEHOT: assert property (@(posedge clk) disable iff (sys_rst) // [R1]
      $onehot0(src_taken))
      else $error("more than one source told it was taken");

   // Vectors of the first source in the polling order and of the keyboard
   AST_VEC_EXT0: assert property (@(posedge clk) disable iff (sys_rst) // [R20]
      irq_req && win_i_r == FLIC_SRC_EXT0 |-> irq_vector == 16'h0003)
      else $error("wrong external 0 vector");

   AST_VEC_KBD: assert property (@(posedge clk) disable iff (sys_rst) // [R14]
      irq_req && win_i_r == FLIC_SRC_KBD |-> irq_vector == 16'h004b)
      else $error("wrong keyboard vector");
endmodule

/* tb/flic_core_model.sv */
// Core and requesting peripherals on the far side of the controller
`timescale 1ns/1ns
module flic_core_model
   import flic_pkg::*;
   (
   input  wire logic        clk,
   input  wire logic        sys_rst,
   input  wire logic [9:0]  raise,
   input  wire logic        take_cmd,
   input  wire logic [1:0]  wait_n,
   input  wire logic        ret_cmd,
   input  wire logic [9:0]  src_taken,
   input  wire logic        irq_req,
   input  wire logic [15:0] irq_vector,
   input  wire logic [1:0]  irq_level,
   output logic      [9:0]  src_req,
   output logic             irq_ack,
   output logic             irq_ret,
   output logic      [15:0] took_vec,
   output logic      [1:0]  took_lvl
   );
   logic       armed_r;
   logic [1:0] cnt_r;

   // Requests stand until taken; the core acks after a chosen delay
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         src_req  <= 10'h0;
         irq_ack  <= 1'b0;
         irq_ret  <= 1'b0;
         armed_r  <= 1'b0;
         cnt_r    <= 2'h0;
         took_vec <= 16'h0;
         took_lvl <= 2'h0;
      end
      else
      begin
         src_req <= (src_req | raise) & ~src_taken;
         irq_ret <= ret_cmd;
         if (take_cmd)
         begin
            armed_r <= 1'b1;
            cnt_r   <= wait_n;
         end
         else if (cnt_r != 2'h0)
            cnt_r <= cnt_r - 2'h1;
         // Ack held until it meets a live request, so no take is lost
         if (irq_ack && irq_req)
         begin
            irq_ack  <= 1'b0;
            armed_r  <= 1'b0;
            took_vec <= irq_vector;
            took_lvl <= irq_level;
         end
         else if (armed_r && cnt_r == 2'h0 && irq_req)
            irq_ack <= 1'b1;
      end
   end
endmodule

/* tb/test_four_level_interrupt_controller.sv */
// Self-checking bench for the four-level interrupt controller
`timescale 1ns/1ns
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin fails++; \
   $display("[FAIL] %s exp %h got %h", n, e, g); end end
module test_four_level_interrupt_controller
   import flic_pkg::*;
   ();
   logic        clk, sys_rst, reg_we, reg_re, bit_we, bit_val, ce;
   logic        take_cmd, ret_cmd, irq_req, irq_ack, irq_ret;
   logic [7:0]  reg_addr, reg_wdata, reg_rdata, rv;
   logic [2:0]  bit_sel;
   logic [1:0]  wait_n, irq_level, took_lvl;
   logic [9:0]  raise, src_req, src_taken, pend;
   logic [15:0] irq_vector, took_vec;
   logic [15:0] vec [10] = '{16'h0003, 16'h000b, 16'h0013, 16'h001b, 16'h0023,
                            16'h002b, 16'h0033, 16'h0043, 16'h004b, 16'h0053};
   int          fails, checks, seed, b, k, n, r;
   int          lv [10];

   flic_ctrl #(.N_SRC(10)) flic_ctrl_inst
   (
      .clk(clk), .sys_rst(sys_rst), .ce(ce), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
      .bit_we(bit_we), .bit_sel(bit_sel), .bit_val(bit_val), .src_req(src_req),
      .src_taken(src_taken), .irq_req(irq_req), .irq_vector(irq_vector),
      .irq_level(irq_level), .irq_ack(irq_ack), .irq_ret(irq_ret)
   );

   flic_core_model flic_core_model_inst
   (
      .clk(clk), .sys_rst(sys_rst), .raise(raise), .take_cmd(take_cmd),
      .wait_n(wait_n), .ret_cmd(ret_cmd), .src_taken(src_taken), .irq_req(irq_req),
      .irq_vector(irq_vector), .irq_level(irq_level), .src_req(src_req),
      .irq_ack(irq_ack), .irq_ret(irq_ret), .took_vec(took_vec), .took_lvl(took_lvl)
   );

   // Free-running system clock
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // Register bus and handshake drivers
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_we <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_we <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      reg_re <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_re <= 1'b0;
      #1 rv = reg_rdata;
   endtask

   task automatic bw(input logic [7:0] a, input logic [2:0] s);
      @(posedge clk);
      bit_we <= 1'b1;
      reg_addr <= a;
      bit_sel <= s;
      bit_val <= 1'b1;
      @(posedge clk);
      bit_we <= 1'b0;
   endtask

   task automatic step(input int c);
      repeat (c) @(posedge clk);
      #1;
   endtask

   task automatic rs(input logic [9:0] m);
      @(posedge clk);
      raise <= m;
      @(posedge clk);
      raise <= 10'h0;
   endtask

   task automatic ret();
      @(posedge clk);
      ret_cmd <= 1'b1;
      @(posedge clk);
      ret_cmd <= 1'b0;
      step(3);
   endtask

   // Ack with a random delay so prompt and slow cores both appear
   task automatic take();
      @(posedge clk);
      take_cmd <= 1'b1;
      wait_n <= 2'($random(seed));
      @(posedge clk);
      take_cmd <= 1'b0;
      #1;
      for (n = 0; n < 40 && src_taken === 10'h0; n++)
         step(1);
      if (n == 40)
         fails++;
   endtask

   // Bit position of a source inside its enable and priority registers
   function automatic logic [2:0] bp(input int i);
      return i < 7 ? 3'(i) : i == 7 ? 3'h2 : i == 8 ? 3'h0 : 3'h6;
   endfunction

   // Reference winner: highest level, then lowest index
   function automatic int best(input logic [9:0] p);
      int w;
      w = -1;
      for (int i = 0; i < 10; i++)
         if (p[i] && (w < 0 || lv[i] > lv[w]))
            w = i;
      return w;
   endfunction

   // Program all priority registers from lv, read back all but the second low one
   task automatic setp();
      logic [7:0] lo, hi, sl, sh;
      lo = 8'h0;
      hi = 8'h0;
      for (int i = 0; i < 7; i++)
      begin
         lo[i] = lv[i][0];
         hi[i] = lv[i][1];
      end
      sl = {1'b0, lv[9][0], 3'h0, lv[7][0], 1'b0, lv[8][0]};
      sh = {1'b0, lv[9][1], 3'h0, lv[7][1], 1'b0, lv[8][1]};
      wr(8'hb8, lo);
      wr(8'hb7, hi);
      wr(8'hb2, sl);
      wr(8'hb3, sh);
      rd(8'hb8);
      `CHK("prio_lo", lo, rv)
      rd(8'hb7);
      `CHK("prio_hi", hi, rv)
      rd(8'hb3);
      `CHK("prio_hi_sec", sh, rv)
   endtask

   task automatic end_sim();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // Watchdog against a hung handshake
   initial
   begin
      repeat (20000) @(posedge clk);
      fails++;
      end_sim();
   end

   // Main sequence
   initial
   begin
      seed = 32'hae6c0f8b;
      fails = 0;
      checks = 0;
      {ce, sys_rst, reg_we, reg_re, bit_we, bit_val, take_cmd, ret_cmd} = 8'hc0;
      {reg_addr, reg_wdata, bit_sel, wait_n, raise} = '0;
      repeat (6) @(posedge clk);
      sys_rst <= 1'b0;
      // Reset values, unmapped address sixth, second priority-high last
      foreach (vec[i])
      begin
         rd(i < 6 ? 8'({8'ha8, 8'hb8, 8'hb7, 8'hb1, 8'hb2, 8'h55} >> (8 * (5 - i))) : 8'hb3);
         `CHK("reset_val", 8'h00, rv)
      end
      foreach (lv[i])
         lv[i] = $random(seed) & 3;
      setp();
      // Each source blocked by global or own enable, then released
      for (k = 0; k < 10; k++)
      begin
         wr(8'ha8, k % 2 ? 8'hff ^ (k < 7 ? 8'h1 << k : 8'h0) : 8'($random(seed)) & 8'h7f);
         wr(8'hb1, 8'h45 ^ (k % 2 && k > 6 ? 8'h1 << bp(k) : 8'h0));
         rs(10'h1 << k);
         step(3);
         `CHK("gated", 1'b0, irq_req)
         bw(8'ha8, 3'h7);
         bw(k < 7 ? 8'ha8 : 8'hb1, bp(k));
         step(2);
         `CHK("enabled", 1'b1, irq_req)
         take();
         `CHK("vector", vec[k], took_vec)
         `CHK("level", 2'(lv[k]), took_lvl)
         `CHK("taken", 10'h1 << k, src_taken)
         ret();
      end
      // Clock enable low must swallow a write
      ce <= 1'b0;
      wr(8'ha8, 8'h00);
      ce <= 1'b1;
      rd(8'ha8);
      `CHK("frozen", 8'hff, rv)
      // Simultaneous requests at random levels, with nesting
      for (r = 0; r < 12; r++)
      begin
         foreach (lv[i])
            lv[i] = $random(seed) & 3;
         setp();
         rs(10'h3ff);
         pend = 10'h3ff;
         while (pend != 10'h0)
         begin
            b = best(pend);
            take();
            `CHK("winner", vec[b], took_vec)
            `CHK("win_level", 2'(lv[b]), took_lvl)
            pend[b] = 1'b0;
            step(2);
            k = best(pend);
            `CHK("preempt", 1'(k >= 0 && lv[k] > lv[b]), irq_req)
            if (irq_req === 1'b1)
            begin
               take();
               `CHK("nested", vec[k], took_vec)
               pend[k] = 1'b0;
               ret();
            end
            ret();
         end
      end
      // Rising levels nest one over another; level 3 blocks all
      foreach (lv[i])
         lv[i] = i % 4;
      setp();
      bw(8'hb7, 3'h0);
      rd(8'hb7);
      `CHK("ph_bitwr", 8'h4c, rv)
      for (k = 0; k < 4; k++)
      begin
         rs(10'h1 << k);
         step(3);
         `CHK("nest_req", 1'b1, irq_req)
         take();
         `CHK("nest_vec", vec[k], took_vec)
      end
      rs(10'h0f0);
      step(3);
      `CHK("top_block", 1'b0, irq_req)
      rd(8'hc0);
      `CHK("status", 8'h0f, rv)
      ret();
      `CHK("after_ret", 1'b1, irq_req)
      take();
      `CHK("top_vec", vec[7], took_vec)
      end_sim();
   end
endmodule
